// ===== src/sss_spread_counter.sv
// Spread spectrum counter with its Avalon-MM register slave
`timescale 1ns/1ns
`default_nettype none
module sss_spread_counter #(
    parameter int CNT_WIDTH = 16
) (
    input  wire logic                    sys_clk,
    input  wire logic                    reset_n,
    input  wire logic [7:0]              avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [31:0]             avs_writedata,
    output var  logic [31:0]             avs_readdata,
    output var  logic                    avs_waitrequest,
    input  wire logic                    sw_protect_status_group3,
    input  wire logic                    hw_protect_status_group3,
    input  wire logic                    channel0_enable,
    input  wire logic                    period_tick,
    output var  logic signed [CNT_WIDTH:0] spread_count,
    output var  logic [CNT_WIDTH+1:0]    effective_period
);
    // The status word and the register layout are built for a 16-bit channel counter
    if (CNT_WIDTH != 16) begin : g_bad_width
        $error("sss_spread_counter: counter width must be 16");
    end

    typedef struct packed {
        logic [23:0]             spread_limit;
        logic                    spread_counter_mode;
        logic [CNT_WIDTH-1:0]    period;
        logic                    enabled;
        logic signed [CNT_WIDTH:0] count;
        logic [CNT_WIDTH+1:0]    effective;
        logic                    answered;
        logic [31:0]             readdata;
    } sss_state_type;

    sss_state_type            state;
    sss_state_type            next_state;
    sss_pkg::sss_bus_req_type req;
    logic [CNT_WIDTH-1:0]     lim;
    logic signed [CNT_WIDTH:0] neg_lim;
    logic signed [CNT_WIDTH:0] pos_lim;
    logic signed [CNT_WIDTH:0] rnd;
    logic                     take_rnd;
    logic                     config_open;

    assign req = '{address: avs_address, read: avs_read, write: avs_write,
                   writedata: avs_writedata};

    function automatic logic [31:0] read_mux(input sss_state_type s, input logic [7:0] a,
                                             input logic sw, input logic hw);
        case (a)
            sss_pkg::SSS_CONFIG_OFFSET: read_mux = {7'h00, s.spread_counter_mode, s.spread_limit};
            sss_pkg::SSS_STATUS_OFFSET: read_mux = {12'h000, s.enabled, hw, sw, s.count[CNT_WIDTH],
                                                    s.count[CNT_WIDTH-1:0]};
            sss_pkg::SSS_PERIOD_OFFSET: read_mux = {16'h0000, s.period};
            sss_pkg::SSS_EFFECT_OFFSET: read_mux = {14'h0000, s.effective};
            default:                    read_mux = sss_pkg::SSS_UNMAPPED_VALUE;
        endcase
    endfunction : read_mux

    // Limit beyond the counter width is ignored
    assign lim      = state.spread_limit[CNT_WIDTH-1:0]; // R2 R8
    assign neg_lim  = -$signed({1'b0, lim});
    assign pos_lim  = $signed({1'b0, lim});
    assign take_rnd = period_tick && state.enabled && state.spread_counter_mode;
    assign config_open = !sw_protect_status_group3 && !hw_protect_status_group3;

    sss_random_range #(
        .WIDTH (CNT_WIDTH)
    ) u_random (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .limit   (lim),
        .take    (take_rnd),
        .value   (rnd)
    );

    always_comb begin
        next_state = state;
        // One wait cycle per access, so readdata comes from a flop
        next_state.answered = (req.read || req.write) && !state.answered;
        if ((req.read || req.write) && !state.answered) begin
            next_state.readdata = req.read ? read_mux(state, req.address,
                                    sw_protect_status_group3, hw_protect_status_group3) : '0;
            if (req.write && req.address == sss_pkg::SSS_CONFIG_OFFSET && config_open) begin // R1
                next_state.spread_limit        = req.writedata[sss_pkg::SSS_LIMIT_MSB:
                                                                sss_pkg::SSS_LIMIT_LSB]; // R8
                next_state.spread_counter_mode = req.writedata[sss_pkg::SSS_MODE_BIT]; // R3
            end
            if (req.write && req.address == sss_pkg::SSS_PERIOD_OFFSET) begin
                next_state.period = req.writedata[CNT_WIDTH-1:0];
            end
        end
        next_state.enabled = channel0_enable;
        // Parked at minus limit while off, so a restart always begins there
        if (!channel0_enable) begin
            next_state.count = neg_lim;
        end else if (!state.enabled) begin
            next_state.count = neg_lim; // R4
        end else if (period_tick) begin
            if (state.spread_counter_mode) begin
                next_state.count = rnd; // R6 R7
            end else if (state.count >= pos_lim) begin
                next_state.count = neg_lim; // R5
            end else begin
                next_state.count = state.count + 1'b1; // R4
            end
        end
        // Sign-extended add; a negative result clamps to zero
        next_state.effective = ($signed({2'b00, state.period}) + state.count < 0) ? '0 :
            (CNT_WIDTH+2)'($signed({2'b00, state.period}) + state.count); // R9
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state.spread_limit        <= sss_pkg::SSS_CONFIG_RESET[23:0];
            state.spread_counter_mode <= sss_pkg::SSS_CONFIG_RESET[sss_pkg::SSS_MODE_BIT];
            state.period              <= sss_pkg::SSS_PERIOD_RESET;
            state.enabled             <= 1'b0;
            state.count               <= '0;
            state.effective           <= '0;
            state.answered            <= 1'b0;
            state.readdata            <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign avs_waitrequest  = (avs_read || avs_write) && !state.answered;
    assign avs_readdata     = state.readdata;
    assign spread_count     = state.count;
    assign effective_period = state.effective;

    // Writes land on the taking edge, the same edge after which waitrequest drops
    sequence s_access_taken;
        (avs_read || avs_write) && !state.answered;
    endsequence

    sequence s_locked_write;
        avs_write && !state.answered && avs_address == sss_pkg::SSS_CONFIG_OFFSET
            && !config_open;
    endsequence

    sequence s_open_config_write;
        avs_write && !state.answered && avs_address == sss_pkg::SSS_CONFIG_OFFSET
            && config_open;
    endsequence

    sequence s_period_write;
        avs_write && !state.answered && avs_address == sss_pkg::SSS_PERIOD_OFFSET;
    endsequence

    sequence s_random_load;
        state.enabled && channel0_enable && period_tick && state.spread_counter_mode;
    endsequence

    AST_ANSWER: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_access_taken ##1 (avs_read || avs_write) |-> !avs_waitrequest)
        else $error("Access not answered after one wait state");
    AST_UNMAPPED: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (avs_read && !state.answered && avs_address != sss_pkg::SSS_CONFIG_OFFSET
            && avs_address != sss_pkg::SSS_STATUS_OFFSET
            && avs_address != sss_pkg::SSS_PERIOD_OFFSET
            && avs_address != sss_pkg::SSS_EFFECT_OFFSET)
            |=> avs_readdata == sss_pkg::SSS_UNMAPPED_VALUE)
        else $error("Unmapped read returned data");
    AST_PERIOD_WRITE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_period_write |=> state.period == $past(avs_writedata[CNT_WIDTH-1:0]))
        else $error("Period not stored");

    AST_LOCKED: assert property (@(posedge sys_clk) disable iff (!reset_n) // R1
        s_locked_write |=> $stable({state.spread_limit, state.spread_counter_mode}))
        else $error("Protected config write took effect");
    AST_OPEN_WRITE: assert property (@(posedge sys_clk) disable iff (!reset_n) // R3
        s_open_config_write |=> state.spread_counter_mode
            == $past(avs_writedata[sss_pkg::SSS_MODE_BIT]))
        else $error("Mode bit not stored");
    AST_STORE_LIMIT: assert property (@(posedge sys_clk) disable iff (!reset_n) // R8
        s_open_config_write |=> state.spread_limit
            == $past(avs_writedata[sss_pkg::SSS_LIMIT_MSB:sss_pkg::SSS_LIMIT_LSB]))
        else $error("Limit field not stored");

    AST_START: assert property (@(posedge sys_clk) disable iff (!reset_n) // R4
        (channel0_enable && !state.enabled) |=> state.count == $past(neg_lim))
        else $error("Counter did not start at minus limit");
    AST_DISABLED: assert property (@(posedge sys_clk) disable iff (!reset_n) // R4
        !channel0_enable |=> state.count == $past(neg_lim))
        else $error("Idle counter not parked at minus limit");
    AST_STEP: assert property (@(posedge sys_clk) disable iff (!reset_n) // R4
        (state.enabled && channel0_enable && period_tick && !state.spread_counter_mode
            && state.count < pos_lim) |=> state.count == $past(state.count) + 1)
        else $error("Triangular step wrong");
    AST_WRAP: assert property (@(posedge sys_clk) disable iff (!reset_n) // R5
        (state.enabled && channel0_enable && period_tick && !state.spread_counter_mode
            && state.count >= pos_lim) |=> state.count == $past(neg_lim))
        else $error("Triangular wrap wrong");
    AST_HOLD: assert property (@(posedge sys_clk) disable iff (!reset_n) // R6
        (state.enabled && channel0_enable && !period_tick) |=> $stable(state.count))
        else $error("Counter moved without a period");
    AST_RANGE: assert property (@(posedge sys_clk) disable iff (!reset_n) // R7
        s_random_load |=> (state.count >= $past(neg_lim) && state.count <= $past(pos_lim)))
        else $error("Random value out of range");
    AST_RANDOM_SRC: assert property (@(posedge sys_clk) disable iff (!reset_n) // R6
        s_random_load |=> state.count == $past(rnd))
        else $error("Random mode did not load the drawn value");
    AST_LIMIT: assert property (@(posedge sys_clk) disable iff (!reset_n) // R2
        s_open_config_write |=> lim == $past(avs_writedata[CNT_WIDTH-1:0]))
        else $error("Limit not taken from low bits");

    // Short periods with a negative spread would underflow, so they clamp at zero
    AST_CLAMP: assert property (@(posedge sys_clk) disable iff (!reset_n) // R9
        ($signed({2'b00, state.period}) + state.count < 0) |=> state.effective == '0)
        else $error("Negative effective period not clamped");
    AST_EFFECT: assert property (@(posedge sys_clk) disable iff (!reset_n) // R9
        ($signed({2'b00, state.period}) + state.count >= 0) |=>
            $signed({1'b0, state.effective}) == $past($signed({2'b00, state.period})
            + state.count))
        else $error("Effective period wrong");
endmodule : sss_spread_counter
`default_nettype wire

// ===== src/sss_pkg.sv
// Package for the spread spectrum counter: register map, fields, types
// How it works
// R1 - Config writes are dropped unless both protect status bits are clear.
// R2 - Only the low 16 limit bits set the counter range.
// R3 - Bit 24 picks the mode: 0 triangular, 1 random.
// R4 - Triangular counter starts at minus limit on channel 0 enable, steps each period.
// R5 - After reaching plus limit, it reloads minus limit at the next period.
// R6 - Random mode loads a fresh random value each period.
// R7 - Random values are uniform over minus limit to plus limit inclusive.
// R8 - The limit field in bits 23:0 is stored; its low 16 bits set the symmetric counter range.
// R9 - Effective period is programmed period plus the signed counter value, clamped at zero.
package sss_pkg;
    localparam logic [7:0]  SSS_CONFIG_OFFSET  = 8'hA0;
    localparam logic [7:0]  SSS_STATUS_OFFSET  = 8'hA4;
    localparam logic [7:0]  SSS_PERIOD_OFFSET  = 8'hA8;
    localparam logic [7:0]  SSS_EFFECT_OFFSET  = 8'hAC;
    localparam int          SSS_LIMIT_LSB      = 0;
    localparam int          SSS_LIMIT_MSB      = 23;
    localparam int          SSS_MODE_BIT       = 24;
    localparam logic [31:0] SSS_CONFIG_RESET   = 32'h0000_0000;
    localparam logic [15:0] SSS_PERIOD_RESET   = 16'h0000;
    localparam logic [31:0] SSS_LFSR_SEED      = 32'hACE1_2D35;
    localparam logic [31:0] SSS_LFSR_TAPS      = 32'h8020_0003;
    localparam logic [31:0] SSS_UNMAPPED_VALUE = 32'h0000_0000;

    typedef struct packed {
        logic [7:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } sss_bus_req_type;

    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
    } sss_bus_rsp_type;
endpackage : sss_pkg

// ===== src/sss_random_range.sv
// Uniform random draw over an inclusive signed range by rejection sampling
`timescale 1ns/1ns
`default_nettype none
module sss_random_range #(
    parameter int WIDTH = 16
) (
    input  wire logic               sys_clk,
    input  wire logic               reset_n,
    input  wire logic [WIDTH-1:0]   limit,
    input  wire logic               take,
    output var  logic signed [WIDTH:0] value
);
    // The draw is cut from the 32-bit shift register, so the width must leave room in it
    if (WIDTH < 2 || WIDTH > 30) begin : g_bad_width
        $error("sss_random_range: WIDTH out of range");
    end

    typedef struct packed {
        logic [31:0]        lfsr;
        logic signed [WIDTH:0] value;
    } sss_rng_state_type;

    sss_rng_state_type state;
    sss_rng_state_type next_state;
    logic [WIDTH:0]    span;
    logic [WIDTH:0]    mask;
    logic [WIDTH:0]    draw;

    // Rejection keeps the draw uniform; a value is always ready from the last accepted draw
    always_comb begin
        next_state = state;
        span = {limit, 1'b0};
        mask = span;
        for (int i = 0; i < WIDTH + 1; i++) begin
            mask = mask | (mask >> 1);
        end
        next_state.lfsr = state.lfsr[0] ? ((state.lfsr >> 1) ^ sss_pkg::SSS_LFSR_TAPS)
                                        : (state.lfsr >> 1);
        draw = state.lfsr[WIDTH:0] & mask;
        if (draw <= span && !take) begin
            // One extra bit keeps draws above the half range from reading as negative
            next_state.value = (WIDTH+1)'($signed({1'b0, draw}) - $signed({2'b00, limit})); // R7
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state.lfsr  <= sss_pkg::SSS_LFSR_SEED;
            state.value <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign value = state.value;
endmodule : sss_random_range
`default_nettype wire

// ===== verification/sss_testbench.sv
// Self-checking bench for the spread spectrum counter and its register slave
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic               sys_clk = 1'b0;
    logic               reset_n = 1'b0;
    logic [7:0]         avs_address = 8'h00;
    logic               avs_read = 1'b0;
    logic               avs_write = 1'b0;
    logic [31:0]        avs_writedata = 32'h0000_0000;
    logic [31:0]        avs_readdata;
    logic               avs_waitrequest;
    logic               sw_prot = 1'b0;
    logic               hw_prot = 1'b0;
    logic               ch0_en = 1'b0;
    logic               tick = 1'b0;
    logic signed [16:0] spread_count;
    logic [17:0]        effective_period;
    int                 n_errors = 0;
    int                 num_checks = 0;
    int                 cycles = 0;
    int                 moved;
    logic [31:0]        seed = 32'hB584;
    logic [31:0]        rd;
    logic [31:0]        cfg;
    logic [15:0]        lim;
    logic [15:0]        per;
    logic signed [16:0] model;
    logic signed [16:0] prev;

    sss_spread_counter #(.CNT_WIDTH(16)) u_dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .sw_protect_status_group3(sw_prot), .hw_protect_status_group3(hw_prot),
        .channel0_enable(ch0_en), .period_tick(tick), .spread_count(spread_count),
        .effective_period(effective_period));

    always #4 sys_clk = ~sys_clk;

    // Cycle ceiling, far above the few hundred cycles the sequence needs
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            conclude();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic signed [16:0] tri_next(input logic signed [16:0] c,
                                                    input logic [15:0] l);
        return (c >= $signed({1'b0, l})) ? -$signed({1'b0, l}) : c + 17'sd1;
    endfunction : tri_next

    // A negative sum clamps to zero
    function automatic logic [17:0] eff_of(input logic [15:0] p,
                                           input logic signed [16:0] c);
        logic signed [18:0] s;
        s = $signed({3'b000, p}) + c;
        return (s < 0) ? 18'h0_0000 : s[17:0];
    endfunction : eff_of

    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    task automatic check_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check_reg

    task automatic check_port(input string what, input logic [17:0] exp, input logic [17:0] got);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check_port

    // Request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge sys_clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= ~wr;
        avs_writedata <= d;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus

    task automatic pulse();
        @(posedge sys_clk);
        tick <= 1'b1;
        @(posedge sys_clk);
        tick <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask : pulse

    initial begin
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        bus(1'b0, sss_pkg::SSS_CONFIG_OFFSET, 32'h0, rd);
        check_reg("config_reset", sss_pkg::SSS_CONFIG_RESET, rd);
        bus(1'b0, 8'h40, 32'h0, rd);
        check_reg("unmapped", sss_pkg::SSS_UNMAPPED_VALUE, rd);
        seed = lfsr(lfsr(seed));
        // Upper limit bits set on purpose: they must not widen the range
        cfg = {8'h00, seed[23:16] | 8'h80, 12'h000, seed[3:0] | 4'h3};
        lim = cfg[15:0];
        bus(1'b1, sss_pkg::SSS_CONFIG_OFFSET, cfg, rd);
        bus(1'b0, sss_pkg::SSS_CONFIG_OFFSET, 32'h0, rd);
        check_reg("config_readback", cfg, rd);
        for (int i = 1; i < 4; i++) begin
            sw_prot <= i[0];
            hw_prot <= i[1];
            bus(1'b1, sss_pkg::SSS_CONFIG_OFFSET, ~cfg, rd);
            bus(1'b0, sss_pkg::SSS_CONFIG_OFFSET, 32'h0, rd);
            check_reg("config_protected", cfg, rd);
        end
        sw_prot <= 1'b0;
        hw_prot <= 1'b0;
        seed = lfsr(seed);
        per = seed[15:0] | 16'h0100;
        bus(1'b1, sss_pkg::SSS_PERIOD_OFFSET, {16'h0000, per}, rd);
        ch0_en <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        model = -$signed({1'b0, lim});
        check_port("start_count", {model[16], model}, {spread_count[16], spread_count});
        bus(1'b0, sss_pkg::SSS_PERIOD_OFFSET, 32'h0, rd);
        check_reg("period", {16'h0000, per}, rd);
        bus(1'b1, sss_pkg::SSS_EFFECT_OFFSET, 32'hFFFF_FFFF, rd);
        bus(1'b0, sss_pkg::SSS_EFFECT_OFFSET, 32'h0, rd);
        check_reg("effective_reg", {14'h0000, eff_of(per, model)}, rd);
        bus(1'b0, sss_pkg::SSS_STATUS_OFFSET, 32'h0, rd);
        check_reg("status", {12'h000, 1'b1, 1'b0, 1'b0, model}, rd);
        for (int k = 0; k < 2 * lim + 3; k++) begin
            pulse();
            model = tri_next(model, lim);
            check_port("tri_count", {model[16], model}, {spread_count[16], spread_count});
            check_port("effective", eff_of(per, model), effective_period);
        end
        @(posedge sys_clk);
        ch0_en <= 1'b0;
        @(posedge sys_clk);
        ch0_en <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        model = -$signed({1'b0, lim});
        check_port("restart_count", {model[16], model}, {spread_count[16], spread_count});
        bus(1'b1, sss_pkg::SSS_CONFIG_OFFSET, cfg | 32'h0100_0000, rd);
        moved = 0;
        prev = spread_count;
        for (int k = 0; k < 24; k++) begin
            pulse();
            check_reg("random_in_range", 32'h1, {31'h0, (spread_count >= model)
                      && (spread_count <= -model)});
            check_port("effective_rnd", eff_of(per, spread_count), effective_period);
            if (spread_count !== prev)
                moved = moved + 1;
            prev = spread_count;
        end
        check_reg("random_moves", 32'h1, {31'h0, moved > 4});
        // Zero period: every negative draw must clamp
        per = 16'h0000;
        bus(1'b1, sss_pkg::SSS_PERIOD_OFFSET, 32'h0, rd);
        for (int k = 0; k < 8; k++) begin
            pulse();
            check_port("effective_clamp", eff_of(per, spread_count), effective_period);
        end
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        bus(1'b0, sss_pkg::SSS_CONFIG_OFFSET, 32'h0, rd);
        check_reg("config_after_reset", sss_pkg::SSS_CONFIG_RESET, rd);
        check_port("count_after_reset", 18'h0_0000, {spread_count[16], spread_count});
        conclude();
    end
endmodule : testbench
`default_nettype wire
